// >>> sig_pkg.sv
// Package of constants and types for the subtract instruction group executor.
package sig_pkg;
    localparam logic [7:0] OFF_OPCODE = 8'h00;
    localparam logic [7:0] OFF_EXT0 = 8'h04;
    localparam logic [7:0] OFF_EXT1 = 8'h08;
    localparam logic [7:0] OFF_DST = 8'h0C;
    localparam logic [7:0] OFF_SRC = 8'h10;
    localparam logic [7:0] OFF_CTRL = 8'h14;
    localparam logic [7:0] OFF_RESULT = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1C;
    localparam logic [7:0] OFF_CCR = 8'h20;
    localparam logic [2:0] OFF_AREG_HI = 3'h2;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [15:0] RST_HALF = 16'h0000;
    localparam logic [4:0] RST_CCR = 5'h00;
    localparam int CCR_C = 0;
    localparam int CCR_V = 1;
    localparam int CCR_Z = 2;
    localparam int CCR_N = 3;
    localparam int CCR_X = 4;
    localparam int CTRL_GO = 0;
    localparam int STS_BUSY = 0;
    localparam int STS_DONE = 1;
    localparam int STS_ILLEGAL = 2;
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    localparam logic [1:0] SZ_BAD = 2'h3;
    localparam logic [2:0] EA_DREG = 3'h0;
    localparam logic [2:0] EA_AREG = 3'h1;
    localparam logic [2:0] EA_IND = 3'h2;
    localparam logic [2:0] EA_IDX = 3'h6;
    localparam logic [2:0] EA_EXT = 3'h7;
    localparam logic [2:0] EA_ABS_L = 3'h1;
    localparam logic [2:0] EA_IMM = 3'h4;
    localparam logic [2:0] OPM_ADDR_W = 3'h3;
    localparam logic [2:0] OPM_ADDR_L = 3'h7;
    localparam logic [3:0] OPC_SUB = 4'h9;
    localparam logic [3:0] OPC_QUICK = 4'h5;
    localparam logic [7:0] OPC_IMM = 8'h04;
    localparam logic [3:0] QUICK_ZERO_VAL = 4'h8;
    typedef enum logic [2:0] {FORM_NONE, FORM_SUB_REG, FORM_SUB_MEM, FORM_ADDR, FORM_IMM, FORM_QUICK} sig_form_e;
    typedef enum logic {ST_IDLE, ST_EXEC} sig_state_e;
endpackage

// >>> sig_decode.sv
// Opcode decoder with addressing-mode legality checks.
`timescale 1ns/1ps
module sig_decode
    import sig_pkg::*;
(
    input wire logic [15:0] opcode,
    output sig_form_e form,
    output logic legal,
    output logic [1:0] size,
    output logic dst_areg,
    output logic flag_update,
    output logic sext_word
);
    logic [2:0] mode;
    logic [2:0] rg;
    logic [2:0] opm;

    function automatic logic mem_alt(input logic [2:0] m, input logic [2:0] r);
        return (m >= EA_IND && m <= EA_IDX) || (m == EA_EXT && r <= EA_ABS_L);
    endfunction

    function automatic logic data_alt(input logic [2:0] m, input logic [2:0] r);
        return m == EA_DREG || mem_alt(m, r);
    endfunction

    function automatic logic src_any(input logic [2:0] m, input logic [2:0] r);
        return m != EA_EXT || r <= EA_IMM;
    endfunction

    assign mode = opcode[5:3];
    assign rg = opcode[2:0];
    assign opm = opcode[8:6];

    always_comb
    begin
        form = FORM_NONE;
        legal = 1'b0;
        size = SZ_LONG;
        dst_areg = 1'b0;
        flag_update = 1'b0;
        sext_word = 1'b0;
        if (opcode[15:12] == OPC_SUB)
        begin
            if (opm == OPM_ADDR_W || opm == OPM_ADDR_L)
            begin
                form = FORM_ADDR;
                dst_areg = 1'b1;
                sext_word = opm == OPM_ADDR_W;
                legal = src_any(mode, rg);
            end
            else if (opm[2])
            begin
                form = FORM_SUB_MEM;
                size = opm[1:0];
                flag_update = 1'b1;
                legal = mem_alt(mode, rg);
            end
            else
            begin
                form = FORM_SUB_REG;
                size = opm[1:0];
                flag_update = 1'b1;
                legal = src_any(mode, rg) && !(mode == EA_AREG && opm[1:0] == SZ_BYTE);
            end
        end
        else if (opcode[15:8] == OPC_IMM)
        begin
            form = FORM_IMM;
            size = opcode[7:6];
            flag_update = 1'b1;
            legal = opcode[7:6] != SZ_BAD && data_alt(mode, rg);
        end
        else if (opcode[15:12] == OPC_QUICK && opcode[8] && opcode[7:6] != SZ_BAD)
        begin
            form = FORM_QUICK;
            size = opcode[7:6];
            if (mode == EA_AREG)
            begin
                dst_areg = 1'b1;
                legal = opcode[7:6] != SZ_BYTE;
                size = SZ_LONG;
            end
            else
            begin
                flag_update = 1'b1;
                legal = data_alt(mode, rg);
            end
        end
    end
endmodule

// >>> sig_alu.sv
// Sized subtractor that produces the result and the five condition flags.
`timescale 1ns/1ps
module sig_alu
    import sig_pkg::*;
(
    input wire logic [1:0] size,
    input wire logic [31:0] dst,
    input wire logic [31:0] src,
    output logic [31:0] result,
    output logic [4:0] flags
);
    logic [4:0] sh;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] mask;
    logic [32:0] diff;

    // Operands are aligned to the top so one 32-bit subtractor yields every width's borrow and sign.
    always_comb
    begin
        sh = (size == SZ_BYTE) ? 5'd24 : (size == SZ_WORD) ? 5'd16 : 5'd0;
        a = dst << sh;
        b = src << sh;
        mask = 32'hFFFF_FFFF >> sh;
        diff = {1'b0, a} - {1'b0, b};
        result = (dst & ~mask) | ((diff[31:0] >> sh) & mask);
        flags[CCR_C] = diff[32];
        flags[CCR_X] = diff[32];
        flags[CCR_N] = diff[31];
        flags[CCR_Z] = diff[31:0] == RST_WORD;
        flags[CCR_V] = (a[31] ^ b[31]) & (a[31] ^ diff[31]);
    end
endmodule

// >>> sig_top.sv
// APB-attached executor for the subtract instruction group.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module sig_top
    import sig_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    logic [15:0] opcode_r;
    logic [15:0] opcode_nxt;
    logic [15:0] ext0_r;
    logic [15:0] ext0_nxt;
    logic [15:0] ext1_r;
    logic [15:0] ext1_nxt;
    logic [31:0] dst_r;
    logic [31:0] dst_nxt;
    logic [31:0] src_r;
    logic [31:0] src_nxt;
    logic [31:0] result_r;
    logic [31:0] result_nxt;
    logic [31:0] areg_r [8];
    logic [31:0] areg_nxt [8];
    logic [4:0] ccr_r;
    logic [4:0] ccr_nxt;
    logic done_r;
    logic done_nxt;
    logic illegal_r;
    logic illegal_nxt;
    sig_state_e state_r;
    sig_state_e state_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pready_r;
    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;

    sig_form_e dec_form;
    logic dec_legal;
    logic [1:0] dec_size;
    logic dec_dst_areg;
    logic dec_flag_update;
    logic dec_sext_word;
    logic [31:0] alu_dst;
    logic [31:0] alu_src;
    logic [31:0] src_raw;
    logic [31:0] alu_result;
    logic [4:0] alu_flags;
    logic [3:0] quick_val;
    logic [2:0] dst_idx;
    logic [2:0] ea_mode;
    logic [2:0] ea_reg;
    logic wr_en;
    logic go;

    function automatic logic is_areg(input logic [7:0] a);
        return a[7:5] == OFF_AREG_HI && a[1:0] == 2'h0;
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        return is_areg(a) || a == OFF_OPCODE || a == OFF_EXT0 || a == OFF_EXT1 || a == OFF_DST
            || a == OFF_SRC || a == OFF_CTRL || a == OFF_RESULT || a == OFF_STATUS || a == OFF_CCR;
    endfunction

    function automatic logic [31:0] imm_value(input logic [1:0] sz, input logic [15:0] w0, input logic [15:0] w1);
        case (sz)
            SZ_BYTE: return {24'h000000, w0[7:0]};
            SZ_WORD: return {16'h0000, w0};
            default: return {w0, w1};
        endcase
    endfunction

    sig_decode u_decode (
        .opcode(opcode_r),
        .form(dec_form),
        .legal(dec_legal),
        .size(dec_size),
        .dst_areg(dec_dst_areg),
        .flag_update(dec_flag_update),
        .sext_word(dec_sext_word)
    );

    sig_alu u_alu (
        .size(dec_size),
        .dst(alu_dst),
        .src(alu_src),
        .result(alu_result),
        .flags(alu_flags)
    );

    assign wr_en = psel && penable && pwrite && pready_r;
    assign go = wr_en && paddr == OFF_CTRL && pwdata[CTRL_GO] && state_r == ST_IDLE;
    assign ea_mode = opcode_r[5:3];
    assign ea_reg = opcode_r[2:0];
    assign quick_val = (opcode_r[11:9] == 3'h0) ? QUICK_ZERO_VAL : {1'b0, opcode_r[11:9]};
    assign dst_idx = (dec_form == FORM_ADDR) ? opcode_r[11:9] : ea_reg;

    // Operand selection; memory and data register values are supplied by software in the operand registers.
    always_comb
    begin
        alu_dst = dec_dst_areg ? areg_r[dst_idx] : dst_r;
        src_raw = src_r;
        if (dec_form == FORM_ADDR || dec_form == FORM_SUB_REG)
        begin
            if (ea_mode == EA_AREG)
            begin
                src_raw = areg_r[ea_reg];
            end
            else if (ea_mode == EA_EXT && ea_reg == EA_IMM)
            begin
                src_raw = imm_value(dec_sext_word ? SZ_WORD : dec_size, ext0_r, ext1_r);
            end
        end
        case (dec_form)
            FORM_ADDR: alu_src = dec_sext_word ? {{16{src_raw[15]}}, src_raw[15:0]} : src_raw;
            FORM_IMM: alu_src = imm_value(dec_size, ext0_r, ext1_r);
            FORM_QUICK: alu_src = {28'h0000000, quick_val};
            default: alu_src = src_raw;
        endcase
    end

    // Software writes land first; execution results override them in the same cycle.
    always_comb
    begin
        opcode_nxt = opcode_r;
        ext0_nxt = ext0_r;
        ext1_nxt = ext1_r;
        dst_nxt = dst_r;
        src_nxt = src_r;
        result_nxt = result_r;
        ccr_nxt = ccr_r;
        done_nxt = done_r;
        illegal_nxt = illegal_r;
        state_nxt = state_r;
        for (int i = 0; i < 8; i++)
        begin
            areg_nxt[i] = areg_r[i];
        end
        if (wr_en)
        begin
            if (is_areg(paddr))
            begin
                areg_nxt[paddr[4:2]] = pwdata;
            end
            case (paddr)
                OFF_OPCODE: opcode_nxt = pwdata[15:0];
                OFF_EXT0: ext0_nxt = pwdata[15:0];
                OFF_EXT1: ext1_nxt = pwdata[15:0];
                OFF_DST: dst_nxt = pwdata;
                OFF_SRC: src_nxt = pwdata;
                OFF_CCR: ccr_nxt = pwdata[4:0];
                default: ;
            endcase
        end
        case (state_r)
            ST_IDLE:
            begin
                if (go)
                begin
                    done_nxt = 1'b0;
                    illegal_nxt = 1'b0;
                    state_nxt = ST_EXEC;
                end
            end
            ST_EXEC:
            begin
                state_nxt = ST_IDLE;
                done_nxt = 1'b1;
                illegal_nxt = !dec_legal;
                if (dec_legal)
                begin
                    result_nxt = alu_result;
                    if (dec_dst_areg)
                    begin
                        areg_nxt[dst_idx] = alu_result;
                    end
                    if (dec_flag_update)
                    begin
                        ccr_nxt = alu_flags;
                    end
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // The slave answers in the first access cycle, so pready is raised by the setup cycle.
    always_comb
    begin
        pready_nxt = psel && !penable;
        pslverr_nxt = psel && !penable && !is_mapped(paddr);
        prdata_nxt = RST_WORD;
        if (psel && !penable && !pwrite)
        begin
            if (is_areg(paddr))
            begin
                prdata_nxt = areg_r[paddr[4:2]];
            end
            case (paddr)
                OFF_OPCODE: prdata_nxt = {16'h0000, opcode_r};
                OFF_EXT0: prdata_nxt = {16'h0000, ext0_r};
                OFF_EXT1: prdata_nxt = {16'h0000, ext1_r};
                OFF_DST: prdata_nxt = dst_r;
                OFF_SRC: prdata_nxt = src_r;
                OFF_RESULT: prdata_nxt = result_r;
                OFF_CCR: prdata_nxt = {27'h0000000, ccr_r};
                OFF_STATUS: prdata_nxt = {25'h0000000, dec_form, 1'b0, illegal_r, done_r, state_r == ST_EXEC};
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            opcode_r <= RST_HALF;
            ext0_r <= RST_HALF;
            ext1_r <= RST_HALF;
            dst_r <= RST_WORD;
            src_r <= RST_WORD;
            result_r <= RST_WORD;
            ccr_r <= RST_CCR;
            done_r <= 1'b0;
            illegal_r <= 1'b0;
            state_r <= ST_IDLE;
            prdata_r <= RST_WORD;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            for (int i = 0; i < 8; i++)
            begin
                areg_r[i] <= RST_WORD;
            end
        end
        else
        begin
            opcode_r <= opcode_nxt;
            ext0_r <= ext0_nxt;
            ext1_r <= ext1_nxt;
            dst_r <= dst_nxt;
            src_r <= src_nxt;
            result_r <= result_nxt;
            ccr_r <= ccr_nxt;
            done_r <= done_nxt;
            illegal_r <= illegal_nxt;
            state_r <= state_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            for (int i = 0; i < 8; i++)
            begin
                areg_r[i] <= areg_nxt[i];
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    AST_MEM_DST_REG: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == ST_EXEC && dec_form == FORM_SUB_MEM && ea_mode <= EA_AREG |=> illegal_r && done_r)
        else $error("Register destination accepted by memory subtract.");

    AST_ADDR_FLAGS_KEPT: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == ST_EXEC && dec_form == FORM_ADDR && !wr_en |=> ccr_r == $past(ccr_r))
        else $error("Address subtract changed the flags.");

    AST_ADDR_WRITEBACK: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == ST_EXEC && dec_form == FORM_ADDR && dec_legal
        |=> areg_r[$past(dst_idx)] == $past(alu_dst) - $past(alu_src))
        else $error("Address subtract wrote a wrong difference.");

    AST_ADDR_WORD_SEXT: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == ST_EXEC && dec_form == FORM_ADDR && opcode_r[8:6] == OPM_ADDR_W
        |-> alu_src == {{16{src_raw[15]}}, src_raw[15:0]} && dec_size == SZ_LONG)
        else $error("Word source not sign-extended.");

    AST_ADDR_SRC_ANY: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == ST_EXEC && dec_form == FORM_ADDR && (ea_mode != EA_EXT || ea_reg <= EA_IMM) |=> !illegal_r)
        else $error("Valid address subtract source refused.");

    AST_IMM_BYTE: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == ST_EXEC && dec_form == FORM_IMM && dec_size == SZ_BYTE |-> alu_src == {24'h000000, ext0_r[7:0]})
        else $error("Byte immediate not taken from low byte.");

    AST_IMM_AREG_DST: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == ST_EXEC && dec_form == FORM_IMM && ea_mode == EA_AREG |=> illegal_r)
        else $error("Immediate subtract took an address register.");

    AST_FLAG_EXTEND: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == ST_EXEC && dec_legal && dec_flag_update
        |=> ccr_r[CCR_X] == ccr_r[CCR_C] && ccr_r == $past(alu_flags))
        else $error("Flags not updated from the subtract.");

    AST_QUICK_BYTE_AREG: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == ST_EXEC && dec_form == FORM_QUICK && ea_mode == EA_AREG && opcode_r[7:6] == SZ_BYTE
        |=> illegal_r)
        else $error("Byte quick subtract to address register accepted.");

    AST_QUICK_FULL: assert property (@(posedge pclk) disable iff (!presetn)
        dec_form == FORM_QUICK && ea_mode == EA_AREG |-> dec_size == SZ_LONG && !dec_flag_update)
        else $error("Quick subtract to address register not full width.");

    AST_QUICK_EIGHT: assert property (@(posedge pclk) disable iff (!presetn)
        dec_form == FORM_QUICK && opcode_r[11:9] == 3'h0 |-> alu_src == 32'h0000_0008)
        else $error("Quick zero code not decoded as eight.");

    AST_ILLEGAL_NO_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == ST_EXEC && !dec_legal && !wr_en |=> result_r == $past(result_r) && ccr_r == $past(ccr_r))
        else $error("Illegal instruction changed state.");

    AST_APB_ANSWER: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready ##1 !pready)
        else $error("APB answer not a single access cycle.");

    AST_MEM_DST_LEGAL: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == ST_EXEC && dec_form == FORM_SUB_MEM && ea_mode >= EA_IND && ea_mode <= EA_IDX
        |=> !illegal_r && done_r)
        else $error("Memory destination refused by memory subtract.");

    AST_ADDR_AREG_SRC: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == ST_EXEC && dec_form == FORM_ADDR && ea_mode == EA_AREG && opcode_r[8:6] == OPM_ADDR_L
        |-> alu_src == areg_r[ea_reg])
        else $error("Address register source not taken from the register file.");

    AST_IMM_LONG_RESULT: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == ST_EXEC && dec_form == FORM_IMM && dec_legal && dec_size == SZ_LONG
        |=> result_r == $past(dst_r) - $past(alu_src))
        else $error("Long immediate subtract stored a wrong difference.");

    AST_IMM_WIDE: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == ST_EXEC && dec_form == FORM_IMM && dec_size != SZ_BYTE
        |-> alu_src == ((dec_size == SZ_WORD) ? {16'h0000, ext0_r} : {ext0_r, ext1_r}))
        else $error("Word or long immediate not taken from the extension words.");

    AST_QUICK_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
        dec_form == FORM_QUICK |-> alu_src >= 32'h0000_0001 && alu_src <= 32'h0000_0008)
        else $error("Quick constant outside one to eight.");

    AST_QUICK_AREG_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == ST_EXEC && dec_form == FORM_QUICK && dec_dst_areg && !wr_en |=> ccr_r == $past(ccr_r))
        else $error("Quick subtract to address register changed the flags.");

    AST_QUICK_AREG_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == ST_EXEC && dec_form == FORM_QUICK && dec_dst_areg && dec_legal
        |=> areg_r[$past(ea_reg)] == $past(areg_r[ea_reg]) - $past(alu_src))
        else $error("Quick subtract did not update the full address register.");
endmodule

// >>> tb_subtract_instruction_group.sv
// Self-checking bench for the subtract instruction group executor over APB.
`timescale 1ns/1ps
module tb_subtract_instruction_group;
    import sig_pkg::*;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    integer err_total = 0;
    integer comparisons = 0;
    integer cycles = 0;
    integer seed = 32'hBD90;
    integer f, j, s, d, k, r, q;
    logic [31:0] rd, e0, e1, dv, sv, iv, res_m, ccr_m;
    logic [31:0] areg_m [8];
    logic [1:0] sz;
    logic [15:0] op;
    logic [5:0] ea;
    logic er, ill;
    logic [5:0] eas [9] = '{6'h00, 6'h08, 6'h17, 6'h35, 6'h38, 6'h39, 6'h3C, 6'h3A, 6'h3B};
    logic [8:0] legi = 9'h03D;
    logic [8:0] legm = 9'h03C;
    sig_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    always #10 pclk = ~pclk;
    task automatic conclude();
        if (err_total == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // A hung handshake would stall the run, so a cycle ceiling ends it.
    always @(posedge pclk)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            err_total = err_total + 1;
            conclude();
        end
    end
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        apb(1'b0, a, 32'h0000_0000);
        check(name, exp & m, rd & m);
    endtask
    function automatic logic [31:0] model(input logic [1:0] z, input logic [31:0] x, input logic [31:0] y);
        logic [31:0] m, h, t;
        logic c;
        m = (z == SZ_BYTE) ? 32'h0000_00FF : (z == SZ_WORD) ? 32'h0000_FFFF : ALL;
        h = m ^ (m >> 1);
        t = (x - y) & m;
        c = (y & m) > (x & m);
        ccr_m = {27'h0, c, (t & h) != 0, t == 0, ((x ^ y) & (x ^ t) & h) != 0, c};
        return (x & ~m) | t;
    endfunction
    task automatic step(input logic [15:0] op, input logic [31:0] a0, a1, dd, ss, input logic bad, input integer ar);
        apb(1'b1, OFF_OPCODE, {16'h0000, op});
        apb(1'b1, OFF_EXT0, a0);
        apb(1'b1, OFF_EXT1, a1);
        apb(1'b1, OFF_DST, dd);
        apb(1'b1, OFF_SRC, ss);
        apb(1'b1, OFF_CTRL, 32'h0000_0001);
        rchk("status", OFF_STATUS, {29'h0, bad, 2'h2}, 32'h0000_0007);
        rchk("ccr", OFF_CCR, ccr_m, 32'h0000_001F);
        if (ar < 0)
            rchk("result", OFF_RESULT, res_m, ALL);
        else
            rchk("areg", 8'(8'h40 + 4 * ar), areg_m[ar], ALL);
    endtask
    initial
    begin
        res_m = 32'h0000_0000;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rchk("status", OFF_STATUS, 32'h0000_0000, ALL);
        rchk("ccr", OFF_CCR, 32'h0000_0000, ALL);
        rchk("areg", 8'h40, 32'h0000_0000, ALL);
        check("okay", 32'h0000_0000, {31'h0, er});
        rchk("unmapped", 8'h30, 32'h0000_0000, ALL);
        check("slverr", 32'h0000_0001, {31'h0, er});
        for (j = 0; j < 8; j++)
        begin
            areg_m[j] = $random(seed);
            apb(1'b1, 8'(8'h40 + 4 * j), areg_m[j]);
        end
        ccr_m = 32'h0000_001F;
        apb(1'b1, OFF_CCR, ccr_m);
        // Immediate word sources always carry a set sign bit so a missing extension shows.
        for (k = 0; k < 16; k++)
        begin
            r = $random(seed) & 7;
            q = $random(seed) & 7;
            e0 = ($random(seed) & 32'h0000_FFFF) | 32'h0000_8000;
            e1 = $random(seed) & 32'h0000_FFFF;
            sv = $random(seed);
            ea = (k[2:1] == 0) ? {3'h0, 3'(q)} : (k[2:1] == 1) ? {3'h1, 3'(q)} : (k[2:1] == 2) ? 6'h3C : 6'h3A;
            iv = (k[2:1] == 1) ? areg_m[q] : (k[2:1] == 2) ? (k[0] ? {e0[15:0], e1[15:0]} : e0) : sv;
            if (!k[0])
                iv = {{16{iv[15]}}, iv[15:0]};
            areg_m[r] = areg_m[r] - iv;
            op = {4'h9, 3'(r), k[0] ? OPM_ADDR_L : OPM_ADDR_W, ea};
            step(op, e0, e1, $random(seed), sv, 1'b0, r);
        end
        for (d = 0; d < 8; d++)
            for (k = 0; k < 2; k++)
                for (s = 0; s < 4; s++)
                begin
                    sz = s[1:0];
                    dv = $random(seed);
                    iv = (d == 0) ? 32'h0000_0008 : 32'(d);
                    ill = sz == SZ_BAD || (k == 1 && sz == SZ_BYTE);
                    if (!ill && k == 1)
                        areg_m[d] = areg_m[d] - iv;
                    else if (!ill)
                        res_m = model(sz, dv, iv);
                    op = {4'h5, 3'(d), 1'b1, sz, 3'(k), 3'(d)};
                    step(op, 0, 0, dv, 0, ill, k ? d : -1);
                end
        // Form 2 is the register-destination subtract; immediate and quick subtracts can also target a data register.
        for (f = 0; f < 3; f++)
            for (j = 0; j < 9; j++)
                for (s = 0; s < (f ? 3 : 4); s++)
                begin
                    sz = s[1:0];
                    e0 = $random(seed) & 32'h0000_FFFF;
                    e1 = $random(seed) & 32'h0000_FFFF;
                    sv = $random(seed);
                    iv = (sz == SZ_BYTE) ? {24'h0, e0[7:0]} : (sz == SZ_WORD) ? e0 : {e0[15:0], e1[15:0]};
                    if (f == 1 || (f == 2 && j != 6))
                        iv = (f == 2 && j == 1) ? areg_m[0] : sv;
                    dv = (s == 1) ? iv : $random(seed);
                    ill = sz == SZ_BAD || (f == 0 && !legi[j]) || (f == 1 && !legm[j]);
                    ill = ill || (f == 2 && j == 1 && sz == SZ_BYTE);
                    if (!ill)
                        res_m = model(sz, dv, iv);
                    op = (f == 0) ? {8'h04, sz, eas[j]} : {4'h9, 3'h5, f == 1, sz, eas[j]};
                    step(op, e0, e1, dv, sv, ill, -1);
                end
        conclude();
    end
endmodule
